// ### verilog/dac_params.svh
// constants for the converter host port and load control block
`ifndef DAC_PARAMS_SVH
`define DAC_PARAMS_SVH

// serial word layout: target select (2), group address (8), data (14)
`define SERIAL_BITS       24
`define DATA_BITS         14
`define ADDR_BITS         8
`define TARGET_BITS       2
`define DATA_LSB          0
`define ADDR_LSB          14
`define TARGET_LSB        22
`define GROUP_LSB         4
`define GROUP_BITS        4

// timing
`define CLK_PERIOD_NS     20
`define RESET_SEQ_NS      100000
`define CALC_CYCLES       32
`define QUEUE_DEPTH       16

// reset values
`define SYNC_RESET        11'h3f8
`define BUS_RESET         24'h000000

`endif

// ### verilog/dac_pkg.sv
// types shared by the converter host port and load control block
package dac_pkg;

    typedef enum logic [1:0] {
        CALC_IDLE,
        CALC_ISSUE,
        CALC_RUN,
        CALC_RESET
    } calc_state_type;

    typedef logic [23:0] queue_entry_type;

endpackage : dac_pkg

// ### verilog/dac_host_port_and_load_control.sv
// host port, write queue, busy and load control of a multichannel converter
//
// What this block does
// - interface_select high picks serial port, low (default) picks parallel port.
// - frame sync low marks an active serial frame.
// - serial bits shift in on serial clock falling edges, up to 50 MHz.
// - chain_out changes on serial clock rising edges, valid at next fall.
// - chain mode only when chain_mode_select and interface_select are high.
// - parallel port is selected only while chip select is low.
// - parallel write on write strobe rising edge with chip select low.
// - parallel_word is one straight 14-bit word, top line is MSB.
// - upper four address bits choose the channel group(s) written.
// - two target select bits choose data, gain, offset, step or soft reset.
// - clear low grounds every output buffer input without any clock.
// - loads ignored while clear low; outputs stay cleared until next load.
// - clear leaves input and output registers unchanged.
// - busy driven low while computing; with queue_enable high writes keep queuing meanwhile, with it low only one waits.
// - no output register update while busy is low.
// - busy low during reset, parallel port disabled, loads ignored.
// - load falling with busy high copies input registers to outputs.
// - load during busy is remembered and done when busy rises.
// - queue_enable high enables the write queue, default off.
// - reset input falling edge starts a 100 us default-restoring sequence.
`timescale 1ns/1ns
`include "dac_params.svh"

module dac_host_port_and_load_control #(
    parameter int RESET_SEQ_CYCLES = (`RESET_SEQ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int CALC_CYCLES      = `CALC_CYCLES,
    parameter int QUEUE_DEPTH      = `QUEUE_DEPTH
) (
    // system
    input  wire logic                     clk,
    input  wire logic                     rst,
    // straps
    input  wire logic                     interface_select,
    input  wire logic                     chain_mode_select,
    input  wire logic                     queue_enable,
    // serial port
    input  wire logic                     serial_clock,
    input  wire logic                     frame_sync_n,
    input  wire logic                     serial_in,
    output logic                          chain_out,
    // parallel port
    input  wire logic                     chip_select_n,
    input  wire logic                     write_strobe_n,
    input  wire logic [`DATA_BITS-1:0]    parallel_word,
    input  wire logic [`ADDR_BITS-1:0]    group_address,
    input  wire logic                     target_select_lo,
    input  wire logic                     target_select_hi,
    // load, clear, reset, busy
    input  wire logic                     load_outputs_n,
    input  wire logic                     output_clear_n,
    input  wire logic                     reset_n,
    input  wire logic                     busy_in,
    output logic                          busy_out,
    output logic                          busy_oe,
    // toward the register and calculation core
    output logic                          write_valid,
    output logic [`TARGET_BITS-1:0]       write_target,
    output logic [`GROUP_BITS-1:0]        write_group,
    output logic [`ADDR_BITS-`GROUP_BITS-1:0] write_channel,
    output logic [`DATA_BITS-1:0]         write_data,
    output logic                          load_pulse,
    output logic                          restore_defaults,
    output logic                          outputs_grounded
);

    // elaboration stops on values the counters and queue cannot serve
    if (RESET_SEQ_CYCLES < 1 || CALC_CYCLES < 1 || QUEUE_DEPTH < 2) begin : g_bad_params
        $error("unsupported parameter values");
    end

    localparam int QW = $clog2(QUEUE_DEPTH);
    localparam int RW = $clog2(RESET_SEQ_CYCLES + 1);
    localparam int CW = $clog2(CALC_CYCLES + 1);

    // -------------------------------------------------------------
    // serial clock domain
    // -------------------------------------------------------------
    logic [`SERIAL_BITS-1:0] shift_q;
    logic [`SERIAL_BITS-1:0] shift_d;
    logic [`SERIAL_BITS-1:0] word_q;
    logic [`SERIAL_BITS-1:0] word_d;
    logic [4:0]              bit_count_q;
    logic [4:0]              bit_count_d;
    logic                    word_toggle_q;
    logic                    word_toggle_d;
    logic                    chain_q;

    // the frame signal itself clears the bit count, since the serial
    // clock may stand still between frames
    always_comb begin
        shift_d       = shift_q;
        bit_count_d   = bit_count_q;
        word_d        = word_q;
        word_toggle_d = word_toggle_q;
        if (!frame_sync_n) begin
            shift_d = {shift_q[`SERIAL_BITS-2:0], serial_in};
            if (bit_count_q == 5'(`SERIAL_BITS - 1)) begin
                bit_count_d   = 5'h00;
                word_d        = shift_d;
                word_toggle_d = ~word_toggle_q;
            end else begin
                bit_count_d = bit_count_q + 5'h01;
            end
        end
    end

    always_ff @(negedge serial_clock or posedge rst) begin
        if (rst) begin
            shift_q <= `BUS_RESET;
        end else begin
            shift_q <= shift_d;
        end
    end

    always_ff @(negedge serial_clock or posedge rst or posedge frame_sync_n) begin
        if (rst || frame_sync_n) begin
            bit_count_q <= 5'h00;
        end else begin
            bit_count_q <= bit_count_d;
        end
    end

    always_ff @(negedge serial_clock or posedge rst) begin
        if (rst) begin
            word_q        <= `BUS_RESET;
            word_toggle_q <= 1'b0;
        end else begin
            word_q        <= word_d;
            word_toggle_q <= word_toggle_d;
        end
    end

    // the bit leaving the register goes out on the rising edge so the
    // next device in the chain sees it settled at the following fall
    always_ff @(posedge serial_clock or posedge rst) begin
        if (rst) begin
            chain_q <= 1'b0;
        end else begin
            chain_q <= shift_q[`SERIAL_BITS-1];
        end
    end

    assign chain_out = chain_q;

    // -------------------------------------------------------------
    // pin synchronisers into the system clock domain
    // -------------------------------------------------------------
    logic [10:0] pin_s1_q;
    logic [10:0] pin_s2_q;
    logic [10:0] pin_s3_q;
    logic [23:0] bus_s1_q;
    logic [23:0] bus_s2_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= `SYNC_RESET;
            pin_s2_q <= `SYNC_RESET;
            pin_s3_q <= `SYNC_RESET;
            bus_s1_q <= `BUS_RESET;
            bus_s2_q <= `BUS_RESET;
        end else begin
            pin_s1_q <= {word_toggle_q, frame_sync_n, reset_n, busy_in,
                         output_clear_n, load_outputs_n, write_strobe_n,
                         chip_select_n, queue_enable, chain_mode_select,
                         interface_select};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            bus_s1_q <= {target_select_hi, target_select_lo, group_address, parallel_word};
            bus_s2_q <= bus_s1_q;
        end
    end

    logic serial_mode;
    logic chain_mode;
    logic queue_on;
    logic line_busy;
    logic clear_low;
    logic par_write;
    logic ser_word;
    logic chain_word;
    logic load_fall;
    logic reset_fall;

    assign serial_mode = pin_s2_q[0];
    assign chain_mode  = pin_s2_q[0] & pin_s2_q[1];
    assign queue_on    = pin_s2_q[2];
    assign line_busy   = ~pin_s2_q[7];
    assign clear_low   = ~pin_s2_q[6];
    // parallel write: strobe rising while selected
    assign par_write   = ~serial_mode & ~pin_s2_q[3]
                         & pin_s2_q[4] & ~pin_s3_q[4];
    assign ser_word    = serial_mode & ~chain_mode & (pin_s2_q[10] ^ pin_s3_q[10]);
    // in chain mode the word is whatever sits in the register when the
    // frame closes; the serial clock is idle then, so it is stable
    assign chain_word  = chain_mode & pin_s2_q[9] & ~pin_s3_q[9];
    assign load_fall   = ~pin_s2_q[5] & pin_s3_q[5];
    assign reset_fall  = ~pin_s2_q[8] & pin_s3_q[8];

    // -------------------------------------------------------------
    // write queue and calculation sequencer
    // -------------------------------------------------------------
    dac_pkg::queue_entry_type     queue_mem [QUEUE_DEPTH];
    logic [QW-1:0]                head_q, head_d, tail_q, tail_d;
    logic [QW:0]                  fill_q, fill_d;
    dac_pkg::calc_state_type      state_q, state_d;
    logic [RW-1:0]                reset_count_q, reset_count_d;
    logic [CW-1:0]                calc_count_q, calc_count_d;
    dac_pkg::queue_entry_type     out_q, out_d;
    logic                         valid_q, valid_d;
    logic                         pending_q, pending_d;
    logic                         load_q, load_d;
    logic                         grounded_q, grounded_d;
    logic                         restore_q, restore_d;
    dac_pkg::queue_entry_type     in_entry;
    logic                         in_valid;
    logic                         in_ok;
    logic                         pop;

    always_comb begin
        in_entry = `BUS_RESET;
        if (chain_mode) begin
            in_entry = shift_q;
        end else if (serial_mode) begin
            in_entry = word_q;
        end else begin
            in_entry = bus_s2_q;
        end
    end

    assign in_valid = (par_write | ser_word | chain_word) & (state_q != dac_pkg::CALC_RESET);
    // with the queue off only one write may wait; further ones while
    // busy are dropped, which is why the queue exists
    assign in_ok    = queue_on ? (fill_q != (QW+1)'(QUEUE_DEPTH))
                               : (fill_q == '0);
    assign pop      = (state_q == dac_pkg::CALC_IDLE) && (fill_q != '0);

    always_comb begin
        head_d        = head_q;
        tail_d        = tail_q;
        fill_d        = fill_q;
        state_d       = state_q;
        reset_count_d = reset_count_q;
        calc_count_d  = calc_count_q;
        out_d         = out_q;
        valid_d       = 1'b0;
        restore_d     = 1'b0;
        if (in_valid && in_ok) begin
            tail_d = (tail_q == QW'(QUEUE_DEPTH - 1)) ? '0 : tail_q + 1'b1;
        end
        if (pop) begin
            head_d = (head_q == QW'(QUEUE_DEPTH - 1)) ? '0 : head_q + 1'b1;
            out_d  = queue_mem[head_q];
        end
        fill_d = fill_q + (QW+1)'(in_valid && in_ok) - (QW+1)'(pop);
        case (state_q)
            dac_pkg::CALC_IDLE: begin
                if (pop) begin
                    state_d = dac_pkg::CALC_ISSUE;
                end
            end
            dac_pkg::CALC_ISSUE: begin
                valid_d      = 1'b1;
                calc_count_d = CW'(CALC_CYCLES);
                state_d      = dac_pkg::CALC_RUN;
            end
            dac_pkg::CALC_RUN: begin
                calc_count_d = calc_count_q - 1'b1;
                if (calc_count_q == CW'(1)) begin
                    state_d = dac_pkg::CALC_IDLE;
                end
            end
            dac_pkg::CALC_RESET: begin
                // the sequence also lasts as long as the reset pin stays low
                if (reset_count_q != RW'(1)) begin
                    reset_count_d = reset_count_q - 1'b1;
                end else if (pin_s2_q[8]) begin
                    state_d = dac_pkg::CALC_IDLE;
                end
            end
            default: begin
                state_d = dac_pkg::CALC_IDLE;
            end
        endcase
        if (reset_fall) begin
            state_d       = dac_pkg::CALC_RESET;
            reset_count_d = RW'(RESET_SEQ_CYCLES);
            head_d        = '0;
            tail_d        = '0;
            fill_d        = '0;
            valid_d       = 1'b0;
        end
        // registered with the state so it spans the busy reset sequence, except its first cycle after power-up
        restore_d = (state_d == dac_pkg::CALC_RESET);
    end

    always_ff @(posedge clk) begin
        if (in_valid && in_ok) begin
            queue_mem[tail_q] <= in_entry;
        end
    end

    // power-up enters the default-restoring sequence straight away
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            head_q        <= '0;
            tail_q        <= '0;
            fill_q        <= '0;
            state_q       <= dac_pkg::CALC_RESET;
            reset_count_q <= RW'(RESET_SEQ_CYCLES);
            calc_count_q  <= '0;
            out_q         <= `BUS_RESET;
            valid_q       <= 1'b0;
            restore_q     <= 1'b0;
        end else begin
            head_q        <= head_d;
            tail_q        <= tail_d;
            fill_q        <= fill_d;
            state_q       <= state_d;
            reset_count_q <= reset_count_d;
            calc_count_q  <= calc_count_d;
            out_q         <= out_d;
            valid_q       <= valid_d;
            restore_q     <= restore_d;
        end
    end

    // -------------------------------------------------------------
    // load and clear control
    // -------------------------------------------------------------
    logic in_reset;
    logic busy_drive;

    assign in_reset   = (state_q == dac_pkg::CALC_RESET);
    assign busy_drive = in_reset || (state_q != dac_pkg::CALC_IDLE) || pop;

    always_comb begin
        pending_d  = pending_q;
        load_d     = 1'b0;
        grounded_d = grounded_q;
        if (clear_low || in_reset) begin
            grounded_d = 1'b1;
        end
        if (in_reset || reset_fall || clear_low) begin
            pending_d = 1'b0;
        end else if (load_fall && !clear_low) begin
            pending_d = 1'b1;
        end
        // a load taken in the same cycle as the release still counts,
        // because the check reads the updated pending flag, not the stored one
        if (pending_d && !line_busy && !busy_drive && !in_reset) begin
            load_d     = 1'b1;
            pending_d  = 1'b0;
            if (!clear_low) begin
                grounded_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending_q  <= 1'b0;
            load_q     <= 1'b0;
            grounded_q <= 1'b1;
        end else begin
            pending_q  <= pending_d;
            load_q     <= load_d;
            grounded_q <= grounded_d;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    // clear acts straight from the pin so it works with no clock;
    // the stored codes are never touched by it
    assign outputs_grounded = ~output_clear_n | grounded_q;
    assign busy_out         = 1'b0;
    assign busy_oe          = busy_drive;
    assign write_valid      = valid_q;
    assign write_target     = out_q[`TARGET_LSB +: `TARGET_BITS];
    assign write_group      = out_q[`ADDR_LSB + `GROUP_LSB +: `GROUP_BITS];
    assign write_channel    = out_q[`ADDR_LSB +: `GROUP_LSB];
    assign write_data       = out_q[`DATA_LSB +: `DATA_BITS];
    assign load_pulse       = load_q;
    assign restore_defaults = restore_q;

endmodule : dac_host_port_and_load_control

// ### testbench/dac_port_chk.sv
// concurrent checks on the host port and load control outputs
`timescale 1ns/1ns

module dac_port_chk #(
    parameter int RESET_SEQ_CYCLES = 20
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic serial_clock,
    input wire logic chain_out,
    // load, clear and busy
    input wire logic output_clear_n,
    input wire logic busy_in,
    input wire logic busy_oe,
    input wire logic load_pulse,
    input wire logic outputs_grounded,
    // core side
    input wire logic write_valid,
    input wire logic restore_defaults
);
    // slack covers the reset edge and the first registered cycle
    localparam int SEQ_MAX = RESET_SEQ_CYCLES + 4;
    logic fall_val_d;
    logic fall_val_q;

    always_comb fall_val_d = chain_out;
    always_ff @(negedge serial_clock or posedge rst) begin
        if (rst) fall_val_q <= 1'b0;
        else fall_val_q <= fall_val_d;
    end

    sequence s_load_clear_high;
        load_pulse && output_clear_n ##1 output_clear_n;
    endsequence

    a_clear_grounds: assert property (@(posedge clk) disable iff (rst)
        !output_clear_n |-> outputs_grounded) else $error("clear did not ground");
    a_clear_blocks_load: assert property (@(posedge clk) disable iff (rst)
        !output_clear_n [*4] |-> !load_pulse) else $error("load during clear");
    a_load_ungrounds: assert property (@(posedge clk) disable iff (rst)
        s_load_clear_high |-> !outputs_grounded) else $error("load left ground");
    a_ground_release: assert property (@(posedge clk) disable iff (rst)
        $fell(outputs_grounded) |-> load_pulse || $past(load_pulse))
        else $error("ground released without load");
    a_busy_blocks_load: assert property (@(posedge clk) disable iff (rst)
        $rose(load_pulse) |-> $past(busy_in)) else $error("load while busy");
    a_write_busy: assert property (@(posedge clk) disable iff (rst)
        write_valid |=> busy_oe [*8]) else $error("busy dropped early");
    a_reset_quiet: assert property (@(posedge clk) disable iff (rst)
        restore_defaults |-> busy_oe && !write_valid && !load_pulse)
        else $error("activity in reset sequence");
    a_reset_bounded: assert property (@(posedge clk) disable iff (rst)
        $rose(restore_defaults) |-> ##[1:SEQ_MAX] !restore_defaults)
        else $error("reset sequence too long");
    a_chain_edge: assert property (@(posedge serial_clock) disable iff (rst)
        chain_out == fall_val_q) else $error("chain output moved off rise");
endmodule : dac_port_chk

bind dac_host_port_and_load_control dac_port_chk #(
    .RESET_SEQ_CYCLES(RESET_SEQ_CYCLES)
) dac_port_chk_i (
    .clk(clk), .rst(rst), .serial_clock(serial_clock), .chain_out(chain_out),
    .output_clear_n(output_clear_n), .busy_in(busy_in), .busy_oe(busy_oe),
    .load_pulse(load_pulse), .outputs_grounded(outputs_grounded),
    .write_valid(write_valid), .restore_defaults(restore_defaults)
);

// ### testbench/serial_host_model.sv
// host model driving serial frames into the converter port
`timescale 1ns/1ns

module serial_host_model (
    // bench control
    input  wire logic        go,
    input  wire logic [5:0]  bit_count,
    input  wire logic [47:0] frame_data,
    output logic             done,
    output logic [23:0]      echo,
    // serial link
    output logic             serial_clock,
    output logic             frame_sync_n,
    output logic             serial_in,
    input  wire logic        chain_out
);
    initial begin
        serial_clock = 1'b1;
        frame_sync_n = 1'b1;
        serial_in = 1'b0;
        done = 1'b0;
        echo = 24'h000000;
    end

    // 125 ns serial clock, running only inside a frame
    always @(posedge go) begin
        #7 frame_sync_n = 1'b0;
        for (int i = int'(bit_count) - 1; i >= 0; i--) begin
            serial_in = frame_data[i];
            #62 serial_clock = 1'b0;
            echo = {echo[22:0], chain_out};
            #63 serial_clock = 1'b1;
        end
        #62 frame_sync_n = 1'b1;
        // released line has no pull, so it must not keep the last bit
        serial_in = ~serial_in;
        done = ~done;
    end
endmodule : serial_host_model

// ### testbench/dac_host_port_and_load_control_bench.sv
// self-checking bench for the host port and load control block
`timescale 1ns/1ns
`include "dac_params.svh"

module dac_host_port_and_load_control_bench;
    localparam int SEQ = 20;
    logic clk = 1'b0, rst = 1'b1, go = 1'b0, ext_busy = 1'b0, reset_n = 1'b1;
    logic interface_select = 1'b0, chain_mode_select = 1'b0, queue_enable = 1'b0;
    logic chip_select_n = 1'b1, write_strobe_n = 1'b1, target_select_lo = 1'b0;
    logic target_select_hi = 1'b0, load_outputs_n = 1'b1, output_clear_n = 1'b1;
    logic [`DATA_BITS-1:0] parallel_word = 14'h0000;
    logic [`ADDR_BITS-1:0] group_address = 8'h00;
    logic [5:0] bit_count = 6'h18;
    logic [47:0] frame_data = 48'h000000000000;
    logic busy_in, serial_clock, frame_sync_n, serial_in, chain_out, done, busy_out;
    logic busy_oe, write_valid, load_pulse, restore_defaults, outputs_grounded;
    logic [`TARGET_BITS-1:0] write_target;
    logic [`GROUP_BITS-1:0] write_group;
    logic [`ADDR_BITS-`GROUP_BITS-1:0] write_channel;
    logic [`DATA_BITS-1:0] write_data;
    logic [23:0] echo, last_write, exp_word;
    int n_errors = 0, comparisons = 0, n_writes = 0, n_loads = 0, w0 = 0, l0 = 0;

    initial forever #10 clk = ~clk;
    // open-drain busy wire with pull-up, shared with an outside party
    assign busy_in = ~(busy_oe | ext_busy);

    dac_host_port_and_load_control #(.RESET_SEQ_CYCLES(SEQ)) dac_host_port_and_load_control_i (.*);
    serial_host_model serial_host_model_i (.*);

    always @(negedge clk) begin
        if (write_valid === 1'b1) begin
            n_writes++;
            last_write = {write_target, write_group, write_channel, write_data};
        end
        if (load_pulse === 1'b1) n_loads++;
    end

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic compare(input logic [23:0] actual, input logic [23:0] expected);
        comparisons++;
        if (actual !== expected) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, actual, expected);
        end
    endtask : compare

    task automatic pwrite(input logic cs_n, input logic [23:0] w);
        @(posedge clk);
        chip_select_n <= cs_n;
        write_strobe_n <= 1'b0;
        {target_select_hi, target_select_lo} <= w[23:22];
        group_address <= w[21:14];
        parallel_word <= w[13:0];
        tick(4);
        write_strobe_n <= 1'b1;
        tick(4);
        chip_select_n <= 1'b1;
    endtask : pwrite

    task automatic pulse_load;
        @(posedge clk);
        load_outputs_n <= 1'b0;
        tick(4);
        load_outputs_n <= 1'b1;
    endtask : pulse_load

    task automatic send_frame(input logic [5:0] bits, input logic [47:0] data);
        logic old;
        @(posedge clk);
        old = done;
        bit_count <= bits;
        frame_data <= data;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        for (int i = 0; i < 400 && done === old; i++) tick(1);
        compare({23'h0, done ^ old}, 24'h000001);
    endtask : send_frame

    task automatic expect_writes(input int cyc, input int n, input logic [23:0] w);
        repeat (cyc) @(negedge clk);
        #1;
        compare(24'(n_writes - w0), 24'(n));
        if (n > 0) compare(last_write, w);
        w0 = n_writes;
    endtask : expect_writes

    task automatic expect_loads(input int cyc, input int n);
        repeat (cyc) @(negedge clk);
        #1;
        compare(24'(n_loads - l0), 24'(n));
        l0 = n_loads;
    endtask : expect_loads

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        #100000;
        n_errors++;
        $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        end_sim();
    end

    initial begin
        tick(2);
        rst <= 1'b0;
        tick(2);
        @(negedge clk);
        compare({22'h0, restore_defaults, busy_oe}, 24'h000003);
        pulse_load();
        expect_loads(SEQ + 10, 0);
        compare({21'h0, busy_out, busy_oe, outputs_grounded}, 24'h000001);
        $display("test reset sequence done");
        for (int t = 0; t < 4; t++) begin
            exp_word = {t[1:0], 8'h93 ^ 8'(t * 17), 14'h2001 ^ 14'(t * 291)};
            pwrite(1'b0, exp_word);
            expect_writes(60, 1, exp_word);
        end
        pwrite(1'b1, 24'h3c0f0f);
        expect_writes(60, 0, exp_word);
        tick(1);
        interface_select <= 1'b1; // straps move only between transfers
        pwrite(1'b0, 24'h3c0f0f);
        expect_writes(60, 0, exp_word);
        send_frame(6'd24, {24'h000000, 24'h6b1c2d});
        expect_writes(60, 1, 24'h6b1c2d);
        tick(1);
        chain_mode_select <= 1'b1;
        send_frame(6'd48, 48'h9e35a74d2c81);
        expect_writes(60, 1, 24'h4d2c81);
        compare(echo, 24'h9e35a7);
        tick(1);
        chain_mode_select <= 1'b0;
        interface_select <= 1'b0;
        $display("test ports done");
        pulse_load();
        expect_loads(10, 1);
        compare({23'h0, outputs_grounded}, 24'h000000);
        tick(1);
        output_clear_n <= 1'b0;
        @(negedge clk);
        compare({23'h0, outputs_grounded}, 24'h000001);
        pulse_load();
        expect_loads(10, 0);
        tick(1);
        output_clear_n <= 1'b1;
        expect_loads(10, 0);
        compare({23'h0, outputs_grounded}, 24'h000001);
        pulse_load();
        expect_loads(10, 1);
        $display("test clear done");
        pwrite(1'b0, 24'h1f0abc);
        pulse_load();
        expect_loads(5, 0);
        expect_loads(60, 1);
        expect_writes(1, 1, 24'h1f0abc);
        tick(1);
        ext_busy <= 1'b1;
        pulse_load();
        expect_loads(20, 0);
        tick(1);
        ext_busy <= 1'b0;
        expect_loads(10, 1);
        tick(1);
        queue_enable <= 1'b1;
        for (int t = 0; t < 3; t++) pwrite(1'b0, 24'h800123 + 24'(t));
        expect_writes(200, 3, 24'h800125);
        $display("test busy and queue done");
        tick(1);
        queue_enable <= 1'b0;
        reset_n <= 1'b0;
        tick(3);
        reset_n <= 1'b1;
        @(negedge clk);
        compare({22'h0, restore_defaults, busy_oe}, 24'h000003);
        pwrite(1'b0, 24'h555555);
        expect_writes(SEQ + 30, 0, 24'h000000);
        compare({23'h0, restore_defaults}, 24'h000000);
        $display("test reset input done");
        end_sim();
    end
endmodule : dac_host_port_and_load_control_bench
